// >>> core/lmsc_pkg.sv
// Constants and types for the legacy mode status control block
// What this block does
// - Compare-class encodings with status flag clear decode as status transfers
// - Status write takes register or rotated immediate into current or saved
// - Narrow space configuration still raises address exceptions
// - Any exception in a legacy mode enters the matching full-width mode
// - Legacy writes to 00000000..0000001F are blocked and data-abort
// - Legacy combined view carries interrupt masks at bits 27 and 26
// - Privileged mode writes of 00000..00011 enter the four legacy modes
// - Legacy fast mode banks r8-r14 and saved; others r13-r14
// - Exception link value holds return address only, no status bits
// - Privileged legacy status write may select a full-width mode
// - A software trap by itself flushes instruction-stream information
// - Full and ranged barriers both flush everything
package lmsc_pkg;
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1b;
    localparam int MODE_WIDE_BIT = 4;
    localparam int I_BIT = 7;
    localparam int F_BIT = 6;
    localparam int VIEW_I_BIT = 27;
    localparam int VIEW_F_BIT = 26;
    localparam logic [3:0] BANK_USER = 4'h0;
    localparam logic [3:0] BANK_FIQ = 4'h1;
    localparam logic [31:0] VECTOR_TOP = 32'h0000001f;
    localparam logic [31:0] LEGACY_LIMIT = 32'h04000000;
    localparam logic [31:0] RST_STATUS = 32'h000000d3;
    localparam logic [31:0] FLAG_MASK = 32'hf0000000;
    localparam logic [31:0] CTRL_MASK = 32'h000000ff;
    localparam logic [31:0] PC_MASK = 32'h03fffffc;
    localparam logic [7:0] PADDR_CTRL = 8'h00;
    localparam logic [7:0] PADDR_STATUS = 8'h04;
    localparam logic [7:0] PADDR_EVT = 8'h08;
    localparam logic [7:0] PADDR_MASK = 8'h0c;
    localparam logic [7:0] PADDR_FLUSHES = 8'h10;
    localparam int EVT_FLUSH = 0;
    localparam int EVT_VECTOR = 1;
    localparam int EVT_ADDR = 2;
    localparam int EVT_LEGACY = 3;
    localparam int EVT_W = 4;
    localparam int STORE_AW = 4;
    typedef enum logic [2:0] {
        LMSC_EXC_RESET = 3'b000,
        LMSC_EXC_UNDEF = 3'b001,
        LMSC_EXC_TRAP = 3'b010,
        LMSC_EXC_PABT = 3'b011,
        LMSC_EXC_DABT = 3'b100,
        LMSC_EXC_IRQ = 3'b101,
        LMSC_EXC_FIQ = 3'b110
    } lmsc_exc_t;
endpackage : lmsc_pkg

// >>> core/lmsc_store.sv
// Saved status store, one word per privileged mode, registered read
`timescale 1ns/1ps
`default_nettype none
module lmsc_store
    import lmsc_pkg::*;
#(
    parameter int AW = STORE_AW
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem [2**AW];

    // No reset on the array; software sees saved words only after an entry or a privileged saved-status write
    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata <= 32'h00000000;
        end
        else
        begin
            rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
        end
    end
endmodule : lmsc_store
`default_nettype wire

// >>> core/lmsc_core.sv
// Status transfer decode, legacy modes, vector guard and APB registers
`timescale 1ns/1ps
`default_nettype none
module lmsc_core
    import lmsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] reg_operand,
    input wire logic [31:0] pc_in,
    input wire logic exc_req,
    input wire lmsc_exc_t exc_kind,
    input wire logic [31:0] exc_return_pc,
    input wire logic mem_wr_valid,
    input wire logic mem_acc_valid,
    input wire logic [31:0] mem_addr,
    input wire logic ext_abort,
    output logic [31:0] cur_status,
    output logic [31:0] pc_status_view,
    output logic status_xfer,
    output logic [31:0] status_rd_data,
    output logic link_wr,
    output logic [31:0] link_data,
    output logic mem_wr_go,
    output logic data_abort,
    output logic addr_exc,
    output logic flush,
    output logic legacy,
    output logic bank_fiq,
    output logic [3:0] bank_sel,
    output logic irq
);
    typedef struct packed {
        logic [31:0] cur_status;
        logic [31:0] view;
        logic [31:0] rd_data;
        logic [31:0] link_data;
        logic link_wr;
        logic status_xfer;
        logic wr_go;
        logic data_abort;
        logic addr_exc;
        logic flush;
        logic legacy;
        logic bank_fiq;
        logic [3:0] bank_sel;
        logic narrow;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic [15:0] flushes;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } lmsc_state_t;

    lmsc_state_t s;
    lmsc_state_t next_s;
    logic [31:0] saved_rd;
    logic st_we;
    logic [STORE_AW-1:0] st_waddr;
    logic [31:0] st_wdata;
    logic is_xfer;
    logic is_trap;
    logic is_legacy;
    logic priv;
    logic [4:0] rot;
    logic [31:0] imm;
    logic [31:0] src;
    logic [31:0] wmask;
    logic [31:0] new_word;
    logic [4:0] exc_mode;
    logic vec_hit;
    logic far_hit;
    logic apb_do;
    logic [EVT_W-1:0] evt_set;

    lmsc_store #(.AW(STORE_AW)) u_store (
        .pclk(pclk),
        .presetn(presetn),
        .we(st_we),
        .waddr(st_waddr),
        .wdata(st_wdata),
        .raddr(s.cur_status[3:0]),
        .rdata(saved_rd)
    );

    always_comb
    begin
        unique case (exc_kind)
            LMSC_EXC_UNDEF: exc_mode = MODE_UND;
            LMSC_EXC_TRAP: exc_mode = MODE_SVC;
            LMSC_EXC_RESET: exc_mode = MODE_SVC;
            LMSC_EXC_PABT: exc_mode = MODE_ABT;
            LMSC_EXC_DABT: exc_mode = MODE_ABT;
            LMSC_EXC_IRQ: exc_mode = MODE_IRQ;
            LMSC_EXC_FIQ: exc_mode = MODE_FIQ;
            default: exc_mode = MODE_UND;
        endcase
    end

    always_comb
    begin
        next_s = s;
        next_s.link_wr = 1'b0;
        next_s.status_xfer = 1'b0;
        next_s.flush = 1'b0;
        next_s.wr_go = 1'b0;
        next_s.data_abort = 1'b0;
        next_s.addr_exc = 1'b0;
        st_we = 1'b0;
        st_waddr = s.cur_status[3:0];
        st_wdata = s.cur_status;
        evt_set = '0;
        is_legacy = !s.cur_status[MODE_WIDE_BIT];
        priv = s.cur_status[3:0] != BANK_USER;
        // Compare-class encodings with the status flag clear
        is_xfer = instr_valid && instr[27:26] == 2'b00
            && instr[24:23] == 2'b10 && !instr[20];
        is_trap = instr_valid && instr[27:24] == 4'hf;
        rot = {instr[11:8], 1'b0};
        imm = ({24'h000000, instr[7:0]} >> rot)
            | ({24'h000000, instr[7:0]} << (6'd32 - {1'b0, rot}));
        src = instr[25] ? imm : reg_operand;
        wmask = (instr[19] ? FLAG_MASK : 32'h00000000)
            | (instr[16] ? CTRL_MASK : 32'h00000000);
        // Unprivileged writes reach the flags only
        if (!priv)
        begin
            wmask = wmask & FLAG_MASK;
        end
        new_word = (s.cur_status & ~wmask) | (src & wmask);
        vec_hit = mem_wr_valid && is_legacy && mem_addr <= VECTOR_TOP;
        far_hit = mem_acc_valid && is_legacy && s.narrow
            && mem_addr >= LEGACY_LIMIT;

        // Exceptions win over the instruction in the same cycle
        if (exc_req)
        begin
            next_s.cur_status[4:0] = exc_mode;
            next_s.cur_status[I_BIT] = 1'b1;
            if (exc_kind == LMSC_EXC_FIQ || exc_kind == LMSC_EXC_RESET)
            begin
                next_s.cur_status[F_BIT] = 1'b1;
            end
            st_we = 1'b1;
            st_waddr = exc_mode[3:0];
            next_s.link_wr = 1'b1;
            // Return address only; status bits of the combined view dropped
            next_s.link_data = is_legacy ? (exc_return_pc & PC_MASK)
                : exc_return_pc;
        end
        else if (is_xfer)
        begin
            // No legacy gating: these stay usable in every mode
            next_s.status_xfer = 1'b1;
            if (!instr[21])
            begin
                next_s.rd_data = instr[22] ? saved_rd : s.cur_status;
            end
            else if (!instr[22])
            begin
                // Privileged code may enter or leave the legacy modes
                next_s.cur_status = new_word;
                if (!new_word[MODE_WIDE_BIT] && !is_legacy)
                begin
                    evt_set[EVT_LEGACY] = 1'b1;
                end
            end
            else if (priv)
            begin
                st_we = 1'b1;
                st_wdata = (saved_rd & ~wmask) | (src & wmask);
            end
        end

        // A trap with no exception in the same cycle flushes all; ranged and full barriers are one case
        if (is_trap && !exc_req)
        begin
            next_s.flush = 1'b1;
            next_s.flushes = s.flushes + 16'h0001;
            evt_set[EVT_FLUSH] = 1'b1;
        end

        // A far access in the narrow space is an address exception, no write
        next_s.wr_go = mem_wr_valid && !vec_hit && !far_hit
            && !ext_abort;
        next_s.data_abort = vec_hit || ext_abort;
        next_s.addr_exc = far_hit;
        evt_set[EVT_VECTOR] = vec_hit;
        evt_set[EVT_ADDR] = far_hit || ext_abort;

        next_s.legacy = !next_s.cur_status[MODE_WIDE_BIT];
        next_s.bank_fiq = next_s.cur_status[3:0] == BANK_FIQ;
        next_s.bank_sel = next_s.cur_status[3:0];
        next_s.view = pc_in;
        if (next_s.legacy)
        begin
            next_s.view = (pc_in & PC_MASK)
                | (next_s.cur_status & (FLAG_MASK | 32'h00000003));
            next_s.view[VIEW_I_BIT] = next_s.cur_status[I_BIT];
            next_s.view[VIEW_F_BIT] = next_s.cur_status[F_BIT];
        end

        // APB slave with one wait state
        apb_do = psel && penable && s.pready;
        next_s.pready = psel && penable && !s.pready;
        next_s.pslverr = 1'b0;
        if (psel && penable && !s.pready)
        begin
            next_s.prdata = 32'h00000000;
            unique case (paddr)
                PADDR_CTRL: next_s.prdata[0] = s.narrow;
                PADDR_STATUS: next_s.prdata = s.cur_status;
                PADDR_EVT: next_s.prdata[EVT_W-1:0] = s.evt;
                PADDR_MASK: next_s.prdata[EVT_W-1:0] = s.mask;
                PADDR_FLUSHES: next_s.prdata[15:0] = s.flushes;
                default: next_s.pslverr = 1'b1;
            endcase
        end
        next_s.evt = s.evt;
        if (apb_do && pwrite)
        begin
            unique case (paddr)
                PADDR_CTRL: next_s.narrow = pwdata[0];
                PADDR_EVT: next_s.evt = s.evt & ~pwdata[EVT_W-1:0];
                PADDR_MASK: next_s.mask = pwdata[EVT_W-1:0];
                default: next_s.narrow = s.narrow;
            endcase
        end
        // Set after clear so a same-cycle event survives
        next_s.evt = next_s.evt | evt_set;
        next_s.irq = |(next_s.evt & next_s.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.cur_status <= RST_STATUS;
            s.bank_sel <= RST_STATUS[3:0];
        end
        else
        begin
            s <= next_s;
        end
    end

    assign cur_status = s.cur_status;
    assign pc_status_view = s.view;
    assign status_xfer = s.status_xfer;
    assign status_rd_data = s.rd_data;
    assign link_wr = s.link_wr;
    assign link_data = s.link_data;
    assign mem_wr_go = s.wr_go;
    assign data_abort = s.data_abort;
    assign addr_exc = s.addr_exc;
    assign flush = s.flush;
    assign legacy = s.legacy;
    assign bank_fiq = s.bank_fiq;
    assign bank_sel = s.bank_sel;
    assign irq = s.irq;
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_priv_mode_write;
        instr_valid && !exc_req && instr[27:26] == 2'b00
            && instr[24:20] == 5'b10010 && instr[16]
            && s.cur_status[3:0] != BANK_USER;
    endsequence
    sequence s_legacy_value;
        (instr[25] ? imm[4:2] : reg_operand[4:2]) == 3'b000;
    endsequence

    a_decode_status: assert property (is_xfer && !exc_req |=> status_xfer)
        else $error("status transfer not decoded");
    a_addr_range: assert property (far_hit |=> addr_exc && !mem_wr_go)
        else $error("address exception missing");
    a_exc_wide: assert property (exc_req |=> cur_status[MODE_WIDE_BIT] && !legacy)
        else $error("exception left core in legacy mode");
    a_vector_guard: assert property (vec_hit |=> data_abort && !mem_wr_go)
        else $error("vector write not aborted");
    a_view_masks: assert property (legacy |-> pc_status_view[VIEW_I_BIT]
        == cur_status[I_BIT] && pc_status_view[VIEW_F_BIT] == cur_status[F_BIT])
        else $error("mask bits misplaced in combined view");
    a_legacy_entry: assert property (s_priv_mode_write ##0 s_legacy_value
        |=> legacy ##0 bank_sel == cur_status[3:0])
        else $error("legacy mode not entered");
    a_fiq_bank: assert property (legacy && cur_status[3:0] == BANK_FIQ |-> bank_fiq)
        else $error("fast legacy mode not banked");
    a_link_clean: assert property (exc_req && is_legacy |=> link_wr
        && link_data == ($past(exc_return_pc) & PC_MASK))
        else $error("link value carries status bits");
    a_trap_flush: assert property (is_trap && !exc_req |=> flush
        && s.flushes == $past(s.flushes) + 16'h0001)
        else $error("trap did not flush");
    a_flush_pulse: assert property (!is_trap || exc_req
        |=> !flush)
        else $error("flush without trap");
    a_user_locked: assert property (instr_valid && !exc_req && is_xfer
        && instr[21] && !instr[22] && !priv
        |=> $stable(cur_status[7:0]))
        else $error("user write changed mode or masks");
endmodule : lmsc_core
`default_nettype wire

// >>> testbench/lmsc_mem_model.sv
// Memory manager model: aborts legacy accesses beyond the narrow range
`timescale 1ns/1ps
`default_nettype none
module lmsc_mem_model
    import lmsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_acc_valid,
    input wire logic [31:0] mem_addr,
    input wire logic legacy,
    output logic ext_abort
);
    // Registered: a real manager answers a cycle after the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_abort <= 1'b0;
        else
            ext_abort <= mem_acc_valid && legacy
                && mem_addr >= LEGACY_LIMIT;
    end
endmodule : lmsc_mem_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the legacy mode status control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lmsc_pkg::*;
;
    typedef struct {
        logic [31:0] i, op, st;
        logic xf, lg, bf;
    } lmsc_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic instr_valid, exc_req, mem_wr_valid, mem_acc_valid, ext_abort;
    logic status_xfer, link_wr, mem_wr_go, data_abort, addr_exc, flush;
    logic legacy, bank_fiq, irq;
    logic [7:0] paddr;
    logic [3:0] bank_sel;
    logic [31:0] pwdata, prdata, instr, reg_operand, pc_in, exc_return_pc;
    logic [31:0] mem_addr, cur_status, pc_status_view, status_rd_data;
    logic [31:0] link_data, rd;
    lmsc_exc_t exc_kind;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    lmsc_row_t rows [7] = '{
        '{32'he1290000, 32'h000000c2, 32'h000000c2, 1'b1, 1'b1, 1'b0},
        '{32'he1290000, 32'h000000c3, 32'h000000c3, 1'b1, 1'b1, 1'b0},
        '{32'he1290000, 32'h000000c1, 32'h000000c1, 1'b1, 1'b1, 1'b1},
        '{32'he1500000, 32'h000000ff, 32'h000000c1, 1'b0, 1'b1, 1'b1},
        '{32'he32900d3, 32'h00000000, 32'h000000d3, 1'b1, 1'b0, 1'b0},
        '{32'he1290000, 32'h000000c0, 32'h000000c0, 1'b1, 1'b1, 1'b0},
        '{32'he1290000, 32'hf00000d3, 32'hf00000c0, 1'b1, 1'b1, 1'b0}
    };
    lmsc_exc_t ek [7] = '{LMSC_EXC_UNDEF, LMSC_EXC_TRAP, LMSC_EXC_PABT,
        LMSC_EXC_DABT, LMSC_EXC_IRQ, LMSC_EXC_FIQ, LMSC_EXC_RESET};
    logic [4:0] em [7] = '{MODE_UND, MODE_SVC, MODE_ABT, MODE_ABT,
        MODE_IRQ, MODE_FIQ, MODE_SVC};
    logic [31:0] traps [2] = '{32'hef000000, 32'heff00001};

    lmsc_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr,
        .reg_operand, .pc_in, .exc_req, .exc_kind, .exc_return_pc,
        .mem_wr_valid, .mem_acc_valid, .mem_addr, .ext_abort, .cur_status,
        .pc_status_view, .status_xfer, .status_rd_data, .link_wr,
        .link_data, .mem_wr_go, .data_abort, .addr_exc, .flush, .legacy,
        .bank_fiq, .bank_sel, .irq);
    lmsc_mem_model mm (.pclk, .presetn, .mem_acc_valid, .mem_addr,
        .legacy, .ext_abort);

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Waits on pready with no assumed latency; the timeout bounds it
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Registered outputs settle after the edge that ends the access
        #10;
    endtask : apb

    task automatic send(input logic [31:0] i, input logic [31:0] op);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr <= i;
        reg_operand <= op;
        @(posedge pclk);
        instr_valid <= 1'b0;
        #10;
    endtask : send

    task automatic mem(input logic w, input logic [31:0] a);
        @(posedge pclk);
        mem_wr_valid <= w;
        mem_acc_valid <= 1'b1;
        mem_addr <= a;
        @(posedge pclk);
        mem_wr_valid <= 1'b0;
        mem_acc_valid <= 1'b0;
        #10;
    endtask : mem

    initial
    begin
        pclk = 1'b0;
        forever
            #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        {psel, penable, pwrite, instr_valid, exc_req} = '0;
        {mem_wr_valid, mem_acc_valid, paddr, pwdata, instr} = '0;
        reg_operand = '0;
        mem_addr = '0;
        exc_kind = LMSC_EXC_RESET;
        pc_in = 32'h00001234;
        exc_return_pc = 32'hfc001238;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        #10;
        chk("reset status", RST_STATUS, cur_status);
        chk("reset bank", 32'h3, 32'(bank_sel));
        chk("reset view", 32'h0, pc_status_view);
        @(posedge pclk);
        #10;
        chk("full view", pc_in, pc_status_view);
        foreach (rows[k])
        begin
            send(rows[k].i, rows[k].op);
            chk("status", rows[k].st, cur_status);
            chk("xfer", 32'(rows[k].xf), 32'(status_xfer));
            chk("legacy", 32'(rows[k].lg), 32'(legacy));
            chk("bank_fiq", 32'(rows[k].bf), 32'(bank_fiq));
            chk("bank", 32'(rows[k].st[3:0]), 32'(bank_sel));
        end
        send(32'he1000000, 32'h0);
        chk("read", 32'hf00000c0, status_rd_data);
        chk("view", 32'hfc001234, pc_status_view);
        mem(1'b1, 32'h0000001f);
        chk("vec abort", 32'h1, 32'(data_abort));
        chk("vec go", 32'h0, 32'(mem_wr_go));
        mem(1'b1, 32'h00000020);
        chk("wr go", 32'h1, 32'(mem_wr_go));
        mem(1'b0, LEGACY_LIMIT);
        chk("no addr exc", 32'h0, 32'(addr_exc));
        @(posedge pclk);
        #10;
        chk("ext abort", 32'h1, 32'(data_abort));
        apb(1'b1, PADDR_CTRL, 32'h1);
        mem(1'b1, LEGACY_LIMIT);
        chk("addr exc", 32'h1, 32'(addr_exc));
        chk("far go", 32'h0, 32'(mem_wr_go));
        apb(1'b1, PADDR_CTRL, 32'h0);
        foreach (ek[k])
        begin
            @(posedge pclk);
            exc_req <= 1'b1;
            exc_kind <= ek[k];
            @(posedge pclk);
            exc_req <= 1'b0;
            #10;
            chk("mode", 32'(em[k]), 32'(cur_status[4:0]));
            chk("link_wr", 32'h1, 32'(link_wr));
            chk("link", 32'h00001238, link_data);
            send(32'he1290000, 32'h000000c2);
        end
        send(32'he1690000, 32'h50000011);
        send(32'he1400000, 32'h0);
        chk("saved", 32'h50000011, status_rd_data);
        foreach (traps[k])
        begin
            send(traps[k], 32'h0);
            chk("flush", 32'h1, 32'(flush));
        end
        apb(1'b0, PADDR_FLUSHES, 32'h0);
        chk("flush count", 32'h2, rd);
        apb(1'b0, PADDR_EVT, 32'h0);
        chk("events", 32'hf, rd);
        apb(1'b1, PADDR_MASK, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, PADDR_MASK, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, PADDR_EVT, 32'hf);
        apb(1'b0, PADDR_EVT, 32'h0);
        chk("events clr", 32'h0, rd);
        chk("irq clr", 32'h0, 32'(irq));
        apb(1'b0, PADDR_STATUS, 32'h0);
        chk("status reg", 32'h000000c2, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        // Mid-run reset: legacy state must drop back to full supervisor
        presetn <= 1'b0;
        #10;
        chk("mid reset status", RST_STATUS, cur_status);
        chk("mid reset legacy", 32'h0, 32'(legacy));
        chk("mid reset irq", 32'h0, 32'(irq));
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #10;
        chk("mid reset view", pc_in, pc_status_view);
        final_report();
    end
endmodule : testbench
`default_nettype wire
